// ---- handler_io_pkg.sv ----
/*
  Shared constants and types for the handler parallel I/O link.
  Assumes a single 10 MHz clock on both ends; all pins are active low.
*/
package handler_io_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned MEASURE_TRIGGER_N_MIN_US     = 100;
  localparam int unsigned MEASURE_TRIGGER_N_MIN_CYC    =
    (MEASURE_TRIGGER_N_MIN_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
    MEASURE_TRIGGER_N_MIN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DONE_DELAY_US   = 30;
  localparam int unsigned DONE_DELAY_CYC  =
    DONE_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PANEL_W         = 7;
  localparam int unsigned BIN_N           = 13;
  localparam int unsigned RESULT_W        = 15;
  // Positions of the comparator meanings on the shared result lines
  localparam int unsigned POS_MAIN_HIGH   = 0;
  localparam int unsigned POS_MAIN_IN     = 1;
  localparam int unsigned POS_MAIN_LOW    = 2;
  localparam int unsigned POS_SUB_HIGH    = 3;
  localparam int unsigned POS_SUB_IN      = 4;
  localparam int unsigned POS_SUB_LOW     = 5;
  localparam int unsigned POS_PASS        = 6;
  localparam int unsigned POS_NO_BIN      = 13;
  localparam int unsigned POS_SUB_FAIL    = 14;
  localparam logic [14:0] RESULT_IDLE_N   = 15'h7fff;
  typedef enum logic [1:0] {
    JUDGE_HIGH = 2'h0,
    JUDGE_IN   = 2'h1,
    JUDGE_LOW  = 2'h2,
    JUDGE_NONE = 2'h3
  } judge_t;
endpackage

// ---- handler_io_if.sv ----
/*
  Handler I/O wires between instrument and handler.
  Assumes both ends share sys_clk; every line is negative logic.
*/
interface handler_io_if;
  logic        measure_trigger_n;
  logic [6:0]  panel_select_n;
  logic        panel_load_strobe_n;
  logic        selfcal_request_n;
  logic [14:0] result_lines_n;
  logic        analog_done_n;
  logic        measure_done_n;
  logic        error_n;
  modport device (
    input  measure_trigger_n, panel_select_n, panel_load_strobe_n,
           selfcal_request_n,
    output result_lines_n, analog_done_n, measure_done_n, error_n
  );
  modport handler (
    output measure_trigger_n, panel_select_n, panel_load_strobe_n,
           selfcal_request_n,
    input  result_lines_n, analog_done_n, measure_done_n, error_n
  );
endinterface

// ---- handler_io_device.sv ----
/*
  Instrument end of the handler I/O: trigger capture, panel load,
  judgement output and done sequencing.
  Assumes the measurement core answers start with analog/judge pulses.
*/
module handler_io_device
  import handler_io_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  handler_io_if.device                io,
  input  wire logic                   ext_trigger_mode,
  input  wire logic                   bin_mode,
  input  wire logic                   judge_reset_en,
  input  wire logic [15:0]            done_delay_extra,
  output logic                        meas_start,
  output logic                        meas_selfcal,
  output logic                        panel_load,
  output logic [6:0]                  panel_number,
  input  wire logic                   analog_end,
  input  wire logic                   judge_ready,
  input  handler_io_pkg::judge_t      main_judge,
  input  handler_io_pkg::judge_t      sub_judge,
  input  wire logic [12:0]            bin_hit,
  input  wire logic                   sub_fail,
  input  wire logic                   level_abnormal,
  input  wire logic                   low_c_detect,
  input  wire logic                   voltage_abnormal
);
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_ANALOG = 4'b0010,
    ST_JUDGE  = 4'b0100,
    ST_DELAY  = 4'b1000
  } state_t;

  logic [1:0]  measure_trigger_n_sync_reg;
  logic [1:0]  strobe_sync_reg;
  logic [1:0]  cal_sync_reg;
  logic [13:0] psel_sync_reg;
  logic [1:0]  measure_trigger_n_next;
  logic [1:0]  strobe_next;
  logic [1:0]  cal_next;
  logic [13:0] psel_next;
  state_t      state_reg, state_next;
  logic [15:0] low_cnt_reg, low_cnt_next;
  logic        fired_reg, fired_next;
  logic [31:0] dly_reg, dly_next;
  logic [14:0] res_reg, res_next;
  logic        adone_reg, adone_next;
  logic        mdone_reg, mdone_next;
  logic        err_reg, err_next;
  logic        start_reg, start_next;
  logic        cal_reg, cal_next_q;
  logic        load_reg, load_next;
  logic [6:0]  pnum_reg, pnum_next;
  logic [14:0] judged;

  function automatic logic [2:0] judge_onehot(input judge_t j);
    judge_onehot = {j == JUDGE_LOW, j == JUDGE_IN, j == JUDGE_HIGH};
  endfunction

  // Result pattern in active-high sense
  always_comb begin
    judged = '0;
    if (bin_mode) begin
      judged[BIN_N-1:0]   = bin_hit;
      judged[POS_NO_BIN]  = ~|bin_hit;
      judged[POS_SUB_FAIL] = sub_fail;
    end else begin
      judged[POS_MAIN_LOW:POS_MAIN_HIGH] = judge_onehot(main_judge);
      judged[POS_SUB_LOW:POS_SUB_HIGH]   = judge_onehot(sub_judge);
      judged[POS_PASS] =
        (main_judge == JUDGE_IN || main_judge == JUDGE_NONE) &&
        (sub_judge == JUDGE_IN || sub_judge == JUDGE_NONE) &&
        !(main_judge == JUDGE_NONE && sub_judge == JUDGE_NONE);
    end
  end

  always_comb begin
    measure_trigger_n_next   = {measure_trigger_n_sync_reg[0], io.measure_trigger_n};
    strobe_next = {strobe_sync_reg[0], io.panel_load_strobe_n};
    cal_next    = {cal_sync_reg[0], io.selfcal_request_n};
    psel_next   = {psel_sync_reg[6:0], io.panel_select_n};
  end

  always_comb begin
    state_next   = state_reg;
    low_cnt_next = low_cnt_reg;
    fired_next   = fired_reg;
    dly_next     = dly_reg;
    res_next     = res_reg;
    adone_next   = adone_reg;
    mdone_next   = mdone_reg;
    start_next   = 1'b0;
    cal_next_q   = cal_reg;
    load_next    = 1'b0;
    pnum_next    = pnum_reg;
    err_next     = level_abnormal | low_c_detect | voltage_abnormal;
    // Low width counted on the synchronised trigger
    if (measure_trigger_n_sync_reg[1]) begin
      low_cnt_next = '0;
      fired_next   = 1'b0;
    end else if (low_cnt_reg != 16'hffff) begin
      low_cnt_next = low_cnt_reg + 16'h0001;
    end
    unique case (state_reg)
      ST_IDLE: begin
        if (ext_trigger_mode && !fired_reg && !measure_trigger_n_sync_reg[1] &&
            low_cnt_reg >= 16'(MEASURE_TRIGGER_N_MIN_CYC - 1)) begin
          fired_next = 1'b1;
          start_next = 1'b1;
          cal_next_q = ~cal_sync_reg[1];
          if (!strobe_sync_reg[1]) begin
            load_next = 1'b1;
            pnum_next = ~psel_sync_reg[13:7];
          end
          adone_next = 1'b0;
          mdone_next = 1'b0;
          if (judge_reset_en) begin
            res_next = '0;
          end
          state_next = ST_ANALOG;
        end
      end
      ST_ANALOG: begin
        if (analog_end) begin
          adone_next = 1'b1;
          state_next = ST_JUDGE;
        end
      end
      ST_JUDGE: begin
        if (judge_ready) begin
          res_next   = judged;
          dly_next   = 32'(DONE_DELAY_CYC) + 32'(done_delay_extra);
          state_next = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (dly_reg <= 32'h0000_0001) begin
          mdone_next = 1'b1;
          state_next = ST_IDLE;
        end else begin
          dly_next = dly_reg - 32'h0000_0001;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      measure_trigger_n_sync_reg   <= 2'h3;
      strobe_sync_reg <= 2'h3;
      cal_sync_reg    <= 2'h3;
      psel_sync_reg   <= 14'h3fff;
      state_reg       <= ST_IDLE;
      low_cnt_reg     <= '0;
      fired_reg       <= 1'b1;
      dly_reg         <= '0;
      res_reg         <= '0;
      adone_reg       <= 1'b0;
      mdone_reg       <= 1'b0;
      err_reg         <= 1'b0;
      start_reg       <= 1'b0;
      cal_reg         <= 1'b0;
      load_reg        <= 1'b0;
      pnum_reg        <= '0;
    end else begin
      measure_trigger_n_sync_reg   <= measure_trigger_n_next;
      strobe_sync_reg <= strobe_next;
      cal_sync_reg    <= cal_next;
      psel_sync_reg   <= psel_next;
      state_reg       <= state_next;
      low_cnt_reg     <= low_cnt_next;
      fired_reg       <= fired_next;
      dly_reg         <= dly_next;
      res_reg         <= res_next;
      adone_reg       <= adone_next;
      mdone_reg       <= mdone_next;
      err_reg         <= err_next;
      start_reg       <= start_next;
      cal_reg         <= cal_next_q;
      load_reg        <= load_next;
      pnum_reg        <= pnum_next;
    end
  end

  // Pins are negative logic
  assign io.result_lines_n = ~res_reg;
  assign io.analog_done_n  = ~adone_reg;
  assign io.measure_done_n = ~mdone_reg;
  assign io.error_n        = ~err_reg;
  assign meas_start        = start_reg;
  assign meas_selfcal      = cal_reg;
  assign panel_load        = load_reg;
  assign panel_number      = pnum_reg;
endmodule

// ---- handler_io_host.sv ----
/*
  Handler end: drives trigger, panel select and calibration request,
  samples judgement after measurement done.
  Assumes the device answers on the shared interface.
*/
module handler_io_host
  import handler_io_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  handler_io_if.handler    io,
  input  wire logic        go,
  input  wire logic        load_panel,
  input  wire logic [6:0]  panel_number,
  input  wire logic        selfcal,
  output logic             busy,
  output logic             sample_free,
  output logic             result_valid,
  output logic [14:0]      result,
  output logic             error
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_MEASURE_TRIGGER_N = 3'b010,
    H_WAIT = 3'b100
  } hstate_t;

  hstate_t     st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [1:0]  ad_sync_reg, md_sync_reg, er_sync_reg;
  logic [29:0] res_sync_reg;
  logic        md_seen_reg, md_seen_next;
  logic        ad_seen_reg, ad_seen_next;
  logic        measure_trigger_n_reg, measure_trigger_n_next;
  logic [6:0]  psel_reg, psel_next;
  logic        strobe_reg, strobe_next;
  logic        cal_reg, cal_next;
  logic        valid_reg, valid_next;
  logic [14:0] res_reg, res_next;

  always_comb begin
    st_next      = st_reg;
    cnt_next     = cnt_reg;
    measure_trigger_n_next    = measure_trigger_n_reg;
    psel_next    = psel_reg;
    strobe_next  = strobe_reg;
    cal_next     = cal_reg;
    valid_next   = 1'b0;
    res_next     = res_reg;
    md_seen_next = md_sync_reg[1];
    ad_seen_next = ad_sync_reg[1];
    unique case (st_reg)
      H_IDLE: begin
        if (go) begin
          measure_trigger_n_next   = 1'b1;
          psel_next   = panel_number;
          strobe_next = load_panel;
          cal_next    = selfcal;
          cnt_next    = '0;
          st_next     = H_MEASURE_TRIGGER_N;
        end
      end
      H_MEASURE_TRIGGER_N: begin
        // Hold low past the minimum so the device count settles
        if (cnt_reg >= 16'(MEASURE_TRIGGER_N_MIN_CYC + 4)) begin
          measure_trigger_n_next   = 1'b0;
          strobe_next = 1'b0;
          cal_next    = 1'b0;
          st_next     = H_WAIT;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      H_WAIT: begin
        if (md_seen_reg && !md_sync_reg[1]) begin
          res_next   = ~res_sync_reg[29:15];
          valid_next = 1'b1;
          st_next    = H_IDLE;
        end
      end
      default: st_next = H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg       <= H_IDLE;
      cnt_reg      <= '0;
      ad_sync_reg  <= 2'h3;
      md_sync_reg  <= 2'h3;
      er_sync_reg  <= 2'h3;
      res_sync_reg <= 30'h3fff_ffff;
      md_seen_reg  <= 1'b1;
      ad_seen_reg  <= 1'b1;
      measure_trigger_n_reg     <= 1'b0;
      psel_reg     <= '0;
      strobe_reg   <= 1'b0;
      cal_reg      <= 1'b0;
      valid_reg    <= 1'b0;
      res_reg      <= '0;
    end else begin
      st_reg       <= st_next;
      cnt_reg      <= cnt_next;
      ad_sync_reg  <= {ad_sync_reg[0], io.analog_done_n};
      md_sync_reg  <= {md_sync_reg[0], io.measure_done_n};
      er_sync_reg  <= {er_sync_reg[0], io.error_n};
      res_sync_reg <= {res_sync_reg[14:0], io.result_lines_n};
      md_seen_reg  <= md_seen_next;
      ad_seen_reg  <= ad_seen_next;
      measure_trigger_n_reg     <= measure_trigger_n_next;
      psel_reg     <= psel_next;
      strobe_reg   <= strobe_next;
      cal_reg      <= cal_next;
      valid_reg    <= valid_next;
      res_reg      <= res_next;
    end
  end

  assign io.measure_trigger_n   = ~measure_trigger_n_reg;
  assign io.panel_select_n      = ~psel_reg;
  assign io.panel_load_strobe_n = ~strobe_reg;
  assign io.selfcal_request_n   = ~cal_reg;
  assign busy         = (st_reg != H_IDLE);
  assign sample_free  = ~ad_sync_reg[1];
  assign result_valid = valid_reg;
  assign result       = res_reg;
  assign error        = ~er_sync_reg[1];
endmodule

// ---- handler_io_checker.sv ----
/*
  Timing checks on the handler I/O wires.
  Assumes one clock and an active-low asynchronous reset.
*/
module handler_io_checker (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        measure_trigger_n,
  input wire logic [6:0]  panel_select_n,
  input wire logic        panel_load_strobe_n,
  input wire logic        selfcal_request_n,
  input wire logic [14:0] result_lines_n,
  input wire logic        analog_done_n,
  input wire logic        measure_done_n,
  input wire logic        error_n
);
  import handler_io_pkg::*;
  // Two cycles slack for the device's output register
  localparam int MIN_AGE = DONE_DELAY_CYC - 2;
  logic        measure_trigger_n_d_reg, measure_trigger_n_d_next;
  logic [10:0] run_reg, run_next;
  logic [9:0]  age_reg, age_next;
  logic [14:0] last_reg, last_next;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Length of the latest low trigger run, held after release
  always_comb begin
    measure_trigger_n_d_next = measure_trigger_n;
    last_next = result_lines_n;
    run_next = run_reg;
    if (!measure_trigger_n) begin
      run_next = measure_trigger_n_d_reg ? 11'h001 : run_reg + 11'(run_reg != 11'h7ff);
    end
    age_next = age_reg + 10'(age_reg != 10'h3ff);
    if (result_lines_n != last_reg) begin
      age_next = 10'h000;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      measure_trigger_n_d_reg <= 1'b1;
      run_reg <= 11'h000;
      age_reg <= 10'h3ff;
      last_reg <= RESULT_IDLE_N;
    end else begin
      measure_trigger_n_d_reg <= measure_trigger_n_d_next;
      run_reg <= run_next;
      age_reg <= age_next;
      last_reg <= last_next;
    end
  end
  property p_idle_after_reset;
    $rose(rstn) |-> analog_done_n && measure_done_n &&
      result_lines_n == RESULT_IDLE_N;
  endproperty
  property p_measure_trigger_n_width;
    $rose(analog_done_n) |-> run_reg >= MEASURE_TRIGGER_N_MIN_CYC;
  endproperty
  property p_no_retrigger;
    $rose(analog_done_n) |-> !$past(measure_done_n);
  endproperty
  property p_done_pair;
    $rose(measure_done_n) |-> $rose(analog_done_n);
  endproperty
  property p_analog_first;
    $fell(analog_done_n) |-> measure_done_n;
  endproperty
  property p_done_order;
    $fell(measure_done_n) |-> !analog_done_n && age_reg >= MIN_AGE;
  endproperty
  property p_done_stand;
    !measure_done_n && measure_trigger_n |=> !measure_done_n;
  endproperty
  property p_result_hold;
    (!measure_done_n ##1 !measure_done_n) |-> $stable(result_lines_n);
  endproperty
  a_idle_after_reset: assert property (p_idle_after_reset)
    else $error("outputs not idle after reset");
  a_measure_trigger_n_width: assert property (p_measure_trigger_n_width)
    else $error("measurement started on a short trigger");
  a_no_retrigger: assert property (p_no_retrigger)
    else $error("trigger taken while measuring");
  a_done_pair: assert property (p_done_pair)
    else $error("done lines not released together");
  a_analog_first: assert property (p_analog_first)
    else $error("analog done after measure done");
  a_done_order: assert property (p_done_order)
    else $error("measure done too early");
  a_done_stand: assert property (p_done_stand)
    else $error("measure done released without trigger");
  a_result_hold: assert property (p_result_hold)
    else $error("results changed while valid");
  c_measure_done: cover property ($fell(measure_done_n));
  c_analog_done: cover property ($fell(analog_done_n));
  c_error: cover property ($fell(error_n));
endmodule

// ---- measurement_handler_io_tb_top.sv ----
/*
  Testbench joining the instrument and handler ends.
  Assumes the package, interface, design and checker are compiled first.
*/
module measurement_handler_io_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import handler_io_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        go, load_panel, selfcal, bin_mode, judge_reset_en;
  logic        ext_trigger_mode, analog_end, judge_ready, sub_fail;
  logic        level_abnormal, low_c_detect, voltage_abnormal;
  logic        meas_start, meas_selfcal, panel_load, busy, sample_free;
  logic        result_valid, error;
  logic [6:0]  host_panel, dev_panel;
  logic [15:0] done_delay_extra;
  logic [12:0] bin_hit;
  logic [14:0] result;
  judge_t      main_judge, sub_judge;
  int          error_cnt, check_count, seed;
  int          starts = 0;
  handler_io_if io ();
  handler_io_device u_handler_io_device (
    .sys_clk(sys_clk), .rstn(rstn), .io(io),
    .ext_trigger_mode(ext_trigger_mode), .bin_mode(bin_mode),
    .judge_reset_en(judge_reset_en), .done_delay_extra(done_delay_extra),
    .meas_start(meas_start), .meas_selfcal(meas_selfcal),
    .panel_load(panel_load), .panel_number(dev_panel),
    .analog_end(analog_end), .judge_ready(judge_ready),
    .main_judge(main_judge), .sub_judge(sub_judge), .bin_hit(bin_hit),
    .sub_fail(sub_fail), .level_abnormal(level_abnormal),
    .low_c_detect(low_c_detect), .voltage_abnormal(voltage_abnormal));
  handler_io_host u_handler_io_host (
    .sys_clk(sys_clk), .rstn(rstn), .io(io), .go(go),
    .load_panel(load_panel), .panel_number(host_panel), .selfcal(selfcal),
    .busy(busy), .sample_free(sample_free), .result_valid(result_valid),
    .result(result), .error(error));
  handler_io_checker u_handler_io_checker (
    .sys_clk(sys_clk), .rstn(rstn),
    .measure_trigger_n(io.measure_trigger_n),
    .panel_select_n(io.panel_select_n),
    .panel_load_strobe_n(io.panel_load_strobe_n),
    .selfcal_request_n(io.selfcal_request_n),
    .result_lines_n(io.result_lines_n), .analog_done_n(io.analog_done_n),
    .measure_done_n(io.measure_done_n), .error_n(io.error_n));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (meas_start === 1'b1) starts <= starts + 1;
  end
  function automatic logic [14:0] exp_res(logic bm, judge_t mj, judge_t sj,
                                          logic [12:0] bh, logic sf);
    logic [14:0] r;
    r = bm ? {sf, bh == 13'h0000, bh} : 15'h0000;
    if (!bm) begin
      r[2:0] = {mj == JUDGE_LOW, mj == JUDGE_IN, mj == JUDGE_HIGH};
      r[5:3] = {sj == JUDGE_LOW, sj == JUDGE_IN, sj == JUDGE_HIGH};
      r[POS_PASS] = mj inside {JUDGE_IN, JUDGE_NONE} &&
        sj inside {JUDGE_IN, JUDGE_NONE} && !(mj == sj && sj == JUDGE_NONE);
    end
    return r;
  endfunction
  task automatic chk_vec(logic [14:0] got, logic [14:0] exp, string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(logic got, logic exp, string what);
    chk_vec({14'h0000, got}, {14'h0000, exp}, what);
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Bounded wait on meas_start (sel 0) or result_valid (sel 1)
  task automatic wait_for(int sel, int lim);
    int k;
    k = 0;
    while ((sel ? result_valid : meas_start) !== 1'b1 && k < lim) begin
      @(negedge sys_clk);
      k++;
    end
    chk_bit(k < lim, 1'b1, "handshake wait");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end
  initial begin
    logic [14:0] exp_r, prev_r;
    logic [12:0] bh;
    logic [6:0]  pn;
    logic [2:0]  errs;
    logic        ld, cal, jr, sf;
    int          s0;
    {go, load_panel, selfcal, bin_mode, judge_reset_en} = 5'h00;
    {analog_end, judge_ready, sub_fail, ext_trigger_mode} = 4'h1;
    {level_abnormal, low_c_detect, voltage_abnormal} = 3'h0;
    {host_panel, done_delay_extra, bin_hit} = '0;
    main_judge = JUDGE_NONE;
    sub_judge = JUDGE_NONE;
    seed = 85;
    error_cnt = 0;
    check_count = 0;
    prev_r = 15'h0000;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 20; i++) begin
      pn = (i == 0) ? 7'h46 : 7'($random(seed));
      ld = (i == 0) ? 1'b1 : 1'($random(seed));
      cal = 1'($random(seed));
      jr = 1'($random(seed));
      sf = 1'($random(seed));
      bh = (i == 16) ? 13'h0000 : 13'($random(seed));
      errs = (i % 5 == 4) ? 3'($random(seed)) : 3'h0;
      exp_r = exp_res(i >= 16, judge_t'(i % 4), judge_t'(i / 4 % 4), bh, sf);
      s0 = starts;
      @(posedge sys_clk);
      {host_panel, load_panel, selfcal, judge_reset_en} <= {pn, ld, cal, jr};
      {bin_mode, bin_hit, sub_fail} <= {i >= 16, bh, sf};
      {level_abnormal, low_c_detect, voltage_abnormal} <= errs;
      main_judge <= judge_t'(i % 4);
      sub_judge <= judge_t'(i / 4 % 4);
      done_delay_extra <= (i == 1) ? 16'h0000 : 16'($random(seed) & 15);
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      tick(3);
      chk_bit(io.measure_trigger_n, 1'b0, "trigger wire");
      chk_vec({8'h00, io.panel_select_n}, {8'h00, ~pn}, "panel wires");
      chk_bit(io.panel_load_strobe_n, !ld, "strobe wire");
      chk_bit(io.selfcal_request_n, !cal, "selfcal wire");
      chk_bit(busy, 1'b1, "host busy");
      wait_for(0, 1100);
      chk_bit(panel_load, ld, "panel load");
      if (ld) chk_vec({8'h00, dev_panel}, {8'h00, pn}, "panel number");
      chk_bit(meas_selfcal, cal, "selfcal");
      tick(4);
      chk_bit(io.analog_done_n, 1'b1, "analog busy");
      chk_vec(io.result_lines_n, jr ? RESULT_IDLE_N : ~prev_r, "clear");
      @(posedge sys_clk);
      analog_end <= 1'b1;
      @(posedge sys_clk);
      analog_end <= 1'b0;
      tick(4);
      chk_bit(io.analog_done_n, 1'b0, "analog done");
      chk_bit(sample_free, 1'b1, "sample free");
      @(posedge sys_clk);
      judge_ready <= 1'b1;
      @(posedge sys_clk);
      judge_ready <= 1'b0;
      tick(3);
      chk_vec(io.result_lines_n, ~exp_r, "judgement");
      tick(290);
      chk_bit(io.measure_done_n, 1'b1, "done delay");
      wait_for(1, 400);
      chk_vec(result, exp_r, "host result");
      chk_bit(io.measure_done_n, 1'b0, "measure done");
      chk_bit(io.error_n, errs == 3'h0, "error wire");
      chk_bit(error, errs != 3'h0, "host error");
      chk_bit(busy, 1'b0, "host idle");
      chk_vec(15'(starts - s0), 15'h0001, "single start");
      prev_r = exp_r;
      if (i == 10) begin
        // Internal mode: trigger ignored, so the host hangs in its wait
        @(posedge sys_clk);
        ext_trigger_mode <= 1'b0;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        s0 = starts;
        tick(1100);
        chk_vec(15'(starts - s0), 15'h0000, "internal mode");
        chk_bit(io.analog_done_n, 1'b0, "no analog start");
        chk_bit(busy, 1'b1, "host waiting");
        // Only a reset frees the host from that wait
        @(posedge sys_clk);
        rstn <= 1'b0;
        ext_trigger_mode <= 1'b1;
        tick(2);
        chk_vec(io.result_lines_n, RESULT_IDLE_N, "reset lines");
        chk_bit(io.measure_done_n, 1'b1, "reset done idle");
        chk_bit(io.analog_done_n, 1'b1, "reset analog idle");
        @(posedge sys_clk);
        rstn <= 1'b1;
        prev_r = 15'h0000;
        tick(3);
      end
      $display("test %0d done", i);
    end
    stop_test();
  end
endmodule
